/* shared/flash_guard_pkg.sv */
// constants shared by the program flash guard and its page lock checker
package flash_guard_pkg;
  // control register on the special function register bus
  localparam logic [7:0]  CTRL_SFR_ADDR  = 8'h8f;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          WE_BIT         = 0;
  localparam int          EE_BIT         = 1;
  // flash geometry
  localparam int          PAGE_SHIFT     = 9;
  localparam int          PAGE_BITS      = 7;
  localparam logic [15:0] RESERVED_BASE  = 16'hfc00;
  localparam logic [15:0] LOCK_BYTE_64K  = 16'hfbff;
  localparam logic [15:0] LOCK_BYTE_32K  = 16'h7fff;
  localparam logic [6:0]  LOCK_PAGE_64K  = 7'h7d;
  localparam logic [6:0]  LOCK_PAGE_32K  = 7'h3f;
  localparam logic [8:0]  PAGE_OFFS_ZERO = 9'h000;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [7:0]  DENIED_BYTE    = 8'h00;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_FETCH_WAIT,
    ST_IDLE,
    ST_READ
  } guard_state_t;
endpackage : flash_guard_pkg

/* shared/lock_check_if.sv */
// carrier between the guard and its page lock checker
`timescale 1ns/10ps
`default_nettype none
interface lock_check_if;
  logic [7:0] lock_byte;
  logic [6:0] page;
  logic       locked;

  modport owner   (output lock_byte, output page, input locked);
  modport judge   (input lock_byte, input page, output locked);
endinterface : lock_check_if
`default_nettype wire

/* rtl/lock_page_check.sv */
// decides whether a flash page is covered by the security lock byte
`timescale 1ns/10ps
`default_nettype none
module lock_page_check
  import flash_guard_pkg::*;
#(
  parameter logic [6:0] LOCK_PAGE = LOCK_PAGE_64K
)(
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  lock_check_if.judge   chk
);
  logic [7:0] page_count;
  logic       low_hit;
  logic       lock_page_hit;

  always_comb
  begin
    page_count    = ~chk.lock_byte;
    low_hit       = {1'b0, chk.page} < page_count;
    lock_page_hit = (page_count != 8'h00) && (chk.page == LOCK_PAGE);
    chk.locked    = low_hit || lock_page_hit;
  end

  property p_low_pages_locked;
    @(posedge clk_i) disable iff (!rst_n_i)
    (chk.page != LOCK_PAGE) |->
      (chk.locked == ((9'(chk.page) + 9'(chk.lock_byte)) < 9'h0ff));
  endproperty
  a_low_pages_locked: assert property (p_low_pages_locked)
    else $error("low page lock state wrong");

  property p_lock_page_follows;
    @(posedge clk_i) disable iff (!rst_n_i)
    (chk.page == LOCK_PAGE) |-> (chk.locked == (chk.lock_byte != ERASED_BYTE));
  endproperty
  a_lock_page_follows: assert property (p_lock_page_follows)
    else $error("lock byte page lock wrong");
endmodule : lock_page_check
`default_nettype wire

/* rtl/flash_program_store_guard.sv */
// program flash guard: control register, move routing and lock byte protection
`timescale 1ns/10ps
`default_nettype none
module flash_program_store_guard
  import flash_guard_pkg::*;
#(
  parameter bit FLASH_64K = 1'b1
)(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // special function register bus
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic        SFR_WR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  output logic      [7:0]  SFR_RDATA_O,
  // core move requests
  input  wire logic        XMOVE_WR_I,
  input  wire logic        XMOVE_RD_I,
  input  wire logic        CODE_RD_I,
  input  wire logic [15:0] CORE_ADDR_I,
  input  wire logic [7:0]  CORE_WDATA_I,
  input  wire logic        ACCESS_UNPROT_I,
  output logic             CORE_READY_O,
  output logic      [7:0]  CODE_RDATA_O,
  output logic             CODE_RVALID_O,
  // external data RAM side
  output logic             EXT_RAM_RD_O,
  output logic             EXT_RAM_WR_O,
  output logic      [15:0] EXT_RAM_ADDR_O,
  output logic      [7:0]  EXT_RAM_WDATA_O,
  // flash array side
  output logic             FLASH_RD_O,
  output logic             FLASH_WR_O,
  output logic             FLASH_ERASE_O,
  output logic      [15:0] FLASH_ADDR_O,
  output logic      [7:0]  FLASH_WDATA_O,
  input  wire logic [7:0]  FLASH_RDATA_I
);
  localparam logic [15:0] LOCK_ADDR = FLASH_64K ? LOCK_BYTE_64K : LOCK_BYTE_32K;
  localparam logic [6:0]  LOCK_PAGE = FLASH_64K ? LOCK_PAGE_64K : LOCK_PAGE_32K;

  guard_state_t state_reg, state_next;
  logic [1:0]   ctrl_reg, ctrl_next;
  logic [7:0]   lock_reg, lock_next;
  logic [7:0]   sfr_rdata_reg, sfr_rdata_next;
  logic         ready_reg, ready_next;
  logic         deny_reg, deny_next;
  logic [7:0]   code_rdata_reg, code_rdata_next;
  logic         code_rvalid_reg, code_rvalid_next;
  logic         ext_ram_rd_reg, ext_ram_rd_next;
  logic         ext_ram_wr_reg, ext_ram_wr_next;
  logic [15:0]  ext_ram_addr_reg, ext_ram_addr_next;
  logic [7:0]   ext_ram_wdata_reg, ext_ram_wdata_next;
  logic         flash_rd_reg, flash_rd_next;
  logic         flash_wr_reg, flash_wr_next;
  logic         flash_erase_reg, flash_erase_next;
  logic [15:0]  flash_addr_reg, flash_addr_next;
  logic [7:0]   flash_wdata_reg, flash_wdata_next;
  logic         in_user;
  logic         deny;

  lock_check_if lk ();
  assign lk.lock_byte = lock_reg;
  assign lk.page      = CORE_ADDR_I[15:PAGE_SHIFT];

  lock_page_check #(
    .LOCK_PAGE (LOCK_PAGE)
  ) u_lock_check (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .chk     (lk)
  );

  always_comb
  begin
    in_user = CORE_ADDR_I <= LOCK_ADDR;
    deny    = ACCESS_UNPROT_I && lk.locked;

    state_next       = state_reg;
    ctrl_next        = ctrl_reg;
    lock_next        = lock_reg;
    deny_next        = deny_reg;
    code_rdata_next  = code_rdata_reg;
    code_rvalid_next = 1'b0;
    ext_ram_rd_next    = 1'b0;
    ext_ram_wr_next    = 1'b0;
    ext_ram_addr_next  = ext_ram_addr_reg;
    ext_ram_wdata_next = ext_ram_wdata_reg;
    flash_rd_next    = 1'b0;
    flash_wr_next    = 1'b0;
    flash_erase_next = 1'b0;
    flash_addr_next  = flash_addr_reg;
    flash_wdata_next = flash_wdata_reg;
    // reserved bit 2 and unused bits are dropped and read back as zero
    if (SFR_WR_I && (SFR_ADDR_I == CTRL_SFR_ADDR))
      ctrl_next = SFR_WDATA_I[1:0];
    case (state_reg)
      ST_FETCH:
      begin
        // the lock byte is fetched after every reset before any core move request is served; register writes are taken at once
        flash_rd_next   = 1'b1;
        flash_addr_next = LOCK_ADDR;
        state_next      = ST_FETCH_WAIT;
      end
      ST_FETCH_WAIT:
      begin
        lock_next  = FLASH_RDATA_I;
        state_next = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (XMOVE_WR_I)
        begin
          if (!ctrl_reg[WE_BIT])
          begin
            ext_ram_wr_next    = 1'b1;
            ext_ram_addr_next  = CORE_ADDR_I;
            ext_ram_wdata_next = CORE_WDATA_I;
          end
          else if (in_user && !deny)
          begin
            flash_addr_next = CORE_ADDR_I;
            if (ctrl_reg[EE_BIT])
            begin
              flash_erase_next = 1'b1;
              flash_addr_next  = {CORE_ADDR_I[15:PAGE_SHIFT], PAGE_OFFS_ZERO};
              if (CORE_ADDR_I[15:PAGE_SHIFT] == LOCK_ADDR[15:PAGE_SHIFT])
                lock_next = ERASED_BYTE;
            end
            else
            begin
              flash_wr_next    = 1'b1;
              flash_wdata_next = CORE_WDATA_I;
              // programming only clears bits, so the shadow copy does the same
              if (CORE_ADDR_I == LOCK_ADDR)
                lock_next = lock_reg & CORE_WDATA_I;
            end
          end
        end
        else if (XMOVE_RD_I)
        begin
          ext_ram_rd_next   = 1'b1;
          ext_ram_addr_next = CORE_ADDR_I;
        end
        else if (CODE_RD_I)
        begin
          deny_next       = deny || !in_user;
          flash_rd_next   = !(deny || !in_user);
          flash_addr_next = CORE_ADDR_I;
          state_next      = ST_READ;
        end
      end
      ST_READ:
      begin
        code_rvalid_next = 1'b1;
        code_rdata_next  = deny_reg ? DENIED_BYTE : FLASH_RDATA_I;
        deny_next        = 1'b0;
        state_next       = ST_IDLE;
      end
      default: state_next = ST_FETCH;
    endcase

    ready_next     = (state_next == ST_IDLE);
    sfr_rdata_next = (SFR_ADDR_I == CTRL_SFR_ADDR) ? {6'h00, ctrl_next} : 8'h00;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg       <= ST_FETCH;
      ctrl_reg        <= CTRL_RESET[1:0];
      lock_reg        <= ERASED_BYTE;
      sfr_rdata_reg   <= 8'h00;
      ready_reg       <= 1'b0;
      deny_reg        <= 1'b0;
      code_rdata_reg  <= 8'h00;
      code_rvalid_reg <= 1'b0;
      ext_ram_rd_reg    <= 1'b0;
      ext_ram_wr_reg    <= 1'b0;
      ext_ram_addr_reg  <= 16'h0000;
      ext_ram_wdata_reg <= 8'h00;
      flash_rd_reg    <= 1'b0;
      flash_wr_reg    <= 1'b0;
      flash_erase_reg <= 1'b0;
      flash_addr_reg  <= 16'h0000;
      flash_wdata_reg <= 8'h00;
    end
    else
    begin
      state_reg       <= state_next;
      ctrl_reg        <= ctrl_next;
      lock_reg        <= lock_next;
      sfr_rdata_reg   <= sfr_rdata_next;
      ready_reg       <= ready_next;
      deny_reg        <= deny_next;
      code_rdata_reg  <= code_rdata_next;
      code_rvalid_reg <= code_rvalid_next;
      ext_ram_rd_reg    <= ext_ram_rd_next;
      ext_ram_wr_reg    <= ext_ram_wr_next;
      ext_ram_addr_reg  <= ext_ram_addr_next;
      ext_ram_wdata_reg <= ext_ram_wdata_next;
      flash_rd_reg    <= flash_rd_next;
      flash_wr_reg    <= flash_wr_next;
      flash_erase_reg <= flash_erase_next;
      flash_addr_reg  <= flash_addr_next;
      flash_wdata_reg <= flash_wdata_next;
    end
  end

  assign SFR_RDATA_O   = sfr_rdata_reg;
  assign CORE_READY_O  = ready_reg;
  assign CODE_RDATA_O  = code_rdata_reg;
  assign CODE_RVALID_O = code_rvalid_reg;
  assign EXT_RAM_RD_O    = ext_ram_rd_reg;
  assign EXT_RAM_WR_O    = ext_ram_wr_reg;
  assign EXT_RAM_ADDR_O  = ext_ram_addr_reg;
  assign EXT_RAM_WDATA_O = ext_ram_wdata_reg;
  assign FLASH_RD_O    = flash_rd_reg;
  assign FLASH_WR_O    = flash_wr_reg;
  assign FLASH_ERASE_O = flash_erase_reg;
  assign FLASH_ADDR_O  = flash_addr_reg;
  assign FLASH_WDATA_O = flash_wdata_reg;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic idle_q;
  assign idle_q = (state_reg == ST_IDLE);
  sequence s_code_req;
    idle_q && CODE_RD_I && !XMOVE_WR_I && !XMOVE_RD_I;
  endsequence
  sequence s_code_ans;
    !CODE_RVALID_O ##1 CODE_RVALID_O && idle_q;
  endsequence
  property p_code_read;
    s_code_req |=> s_code_ans;
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("code read not answered in two cycles");
  property p_xread_to_ext_ram;
    idle_q && XMOVE_RD_I && !XMOVE_WR_I |=>
      EXT_RAM_RD_O && !FLASH_RD_O && !FLASH_WR_O && !FLASH_ERASE_O;
  endproperty
  a_xread_to_ext_ram: assert property (p_xread_to_ext_ram)
    else $error("external-move read not sent to external RAM");
  property p_write_needs_we;
    (FLASH_WR_O || FLASH_ERASE_O) |-> $past(ctrl_reg[WE_BIT]);
  endproperty
  a_write_needs_we: assert property (p_write_needs_we)
    else $error("flash changed with write enable low");
  property p_erase_needs_both;
    FLASH_ERASE_O |-> $past(ctrl_reg) == 2'h3;
  endproperty
  a_erase_needs_both: assert property (p_erase_needs_both)
    else $error("erase without both enables");
  property p_denied_read_zero;
    s_code_req ##0 deny |=> !FLASH_RD_O ##1 CODE_RVALID_O && CODE_RDATA_O == DENIED_BYTE;
  endproperty
  a_denied_read_zero: assert property (p_denied_read_zero)
    else $error("locked page readable by unprotected access");
  property p_denied_no_change;
    idle_q && XMOVE_WR_I && deny |=> !FLASH_WR_O && !FLASH_ERASE_O;
  endproperty
  a_denied_no_change: assert property (p_denied_no_change)
    else $error("locked page changed by unprotected access");
  property p_fetch_lock_addr;
    state_reg == ST_FETCH |=> FLASH_RD_O && FLASH_ADDR_O == LOCK_ADDR;
  endproperty
  a_fetch_lock_addr: assert property (p_fetch_lock_addr)
    else $error("lock byte fetched from wrong address");
  property p_reserved_untouched;
    (FLASH_WR_O || FLASH_ERASE_O) |-> FLASH_ADDR_O <= LOCK_ADDR && FLASH_ADDR_O < RESERVED_BASE;
  endproperty
  a_reserved_untouched: assert property (p_reserved_untouched)
    else $error("reserved flash area modified");
  property p_erase_whole_page;
    idle_q && XMOVE_WR_I && ctrl_reg == 2'h3 && in_user && !deny |=>
      FLASH_ERASE_O && !FLASH_WR_O && FLASH_ADDR_O[15:PAGE_SHIFT] == $past(CORE_ADDR_I[15:PAGE_SHIFT])
      && FLASH_ADDR_O[PAGE_SHIFT-1:0] == PAGE_OFFS_ZERO;
  endproperty
  a_erase_whole_page: assert property (p_erase_whole_page)
    else $error("write with both enables did not erase the page");
endmodule : flash_program_store_guard
`default_nettype wire

/* tb/flash_array_model.sv */
// behavioural program flash array facing the guard
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
  import flash_guard_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic        erase_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:65535];
  // off-cycle data is inverted so a late sample cannot match by luck
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
  // programming only clears bits; only an erase brings a page back to all ones
  always @(posedge clk_i)
  begin
    if (wr_i)
      mem[addr_i] <= mem[addr_i] & wdata_i;
    if (erase_i)
      for (int i = 0; i < 512; i++)
        mem[{addr_i[15:9], 9'(i)}] <= ERASED_BYTE;
  end
endmodule : flash_array_model
`default_nettype wire

/* tb/flash_program_store_guard_tb.sv */
// self-checking bench for the program flash guard
`timescale 1ns/10ps
`default_nettype none
module flash_program_store_guard_tb import flash_guard_pkg::*;;
  logic        clk, rst_n, s_wr, x_wr, x_rd, c_rd, unprot;
  logic [7:0]  s_addr, s_wdata, c_wdata, ctrl_exp;
  logic [15:0] c_addr;
  logic [31:0] rng;
  logic [7:0]  shadow [0:65535];
  int          n_fail, total_checks;
  wire logic        rdy, rvalid, xr, xw, frd, fwr, fer;
  wire logic [7:0]  s_rdata, rdata, xwdata, fwdata, frdata;
  wire logic [15:0] xaddr, faddr;

  flash_program_store_guard #(.FLASH_64K(1'b1)) uut (
    .CLK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(s_addr), .SFR_WR_I(s_wr),
    .SFR_WDATA_I(s_wdata), .SFR_RDATA_O(s_rdata), .XMOVE_WR_I(x_wr),
    .XMOVE_RD_I(x_rd), .CODE_RD_I(c_rd), .CORE_ADDR_I(c_addr),
    .CORE_WDATA_I(c_wdata), .ACCESS_UNPROT_I(unprot), .CORE_READY_O(rdy),
    .CODE_RDATA_O(rdata), .CODE_RVALID_O(rvalid), .EXT_RAM_RD_O(xr), .EXT_RAM_WR_O(xw),
    .EXT_RAM_ADDR_O(xaddr), .EXT_RAM_WDATA_O(xwdata), .FLASH_RD_O(frd), .FLASH_WR_O(fwr),
    .FLASH_ERASE_O(fer), .FLASH_ADDR_O(faddr), .FLASH_WDATA_O(fwdata),
    .FLASH_RDATA_I(frdata));
  flash_array_model flash (
    .clk_i(clk), .rd_i(frd), .wr_i(fwr), .erase_i(fer), .addr_i(faddr),
    .wdata_i(fwdata), .rdata_o(frdata));

  always #5 clk = ~clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // reserved space, or a page covered by the lock byte for unprotected code
  function automatic logic blocked(input logic [15:0] a, input logic u);
    logic [7:0] n;
    n = ~shadow[LOCK_BYTE_64K];
    return (a > LOCK_BYTE_64K) ||
           (u && n != 8'h00 && ({1'b0, a[15:9]} < n || a[15:9] == LOCK_PAGE_64K));
  endfunction : blocked

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wait_ready();
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (rdy !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t ready timeout", $time);
      end_sim();
    end
  endtask : wait_ready

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    s_addr = a;
    @(posedge clk);
    #1;
    chk(s_rdata, exp, "register read");
  endtask : sfr_rd

  task automatic sfr_wr(input logic [7:0] d);
    s_addr = CTRL_SFR_ADDR;
    s_wdata = d;
    s_wr = 1'b1;
    @(posedge clk);
    #1;
    s_wr = 1'b0;
    ctrl_exp = {6'h00, d[1:0]};
  endtask : sfr_wr

  task automatic ext_ram_rd(input logic [15:0] a);
    wait_ready();
    x_rd = 1'b1;
    c_addr = a;
    @(posedge clk);
    #1;
    x_rd = 1'b0;
    chk({xr, frd}, 2'h2, "move read target");
    chk(xaddr, a, "move read address");
    // one idle edge so the strobe never drops and rises in one time step
    @(posedge clk);
    #1;
  endtask : ext_ram_rd

  task automatic core_wr(input logic [15:0] a, input logic [7:0] d, input logic u);
    logic ew, fw, fe;
    wait_ready();
    ew = !ctrl_exp[WE_BIT];
    fw = ctrl_exp[WE_BIT] && !ctrl_exp[EE_BIT] && !blocked(a, u);
    fe = ctrl_exp[WE_BIT] && ctrl_exp[EE_BIT] && !blocked(a, u);
    x_wr = 1'b1;
    c_addr = a;
    c_wdata = d;
    unprot = u;
    @(posedge clk);
    #1;
    x_wr = 1'b0;
    chk(xw, ew, "ram write pulse");
    chk(fwr, fw, "flash write pulse");
    chk(fer, fe, "page erase pulse");
    if (ew)
      chk(xaddr, a, "ram write address");
    if (ew)
      chk(xwdata, d, "ram write data");
    if (fw)
      chk(faddr, a, "flash write address");
    if (fw)
      chk({fwdata, faddr[7:0]}, {d, a[7:0]}, "flash write byte");
    if (fe)
      chk(faddr, {a[15:9], PAGE_OFFS_ZERO}, "erase page address");
    if (fw)
      shadow[a] = shadow[a] & d;
    if (fe)
      for (int i = 0; i < 512; i++)
        shadow[{a[15:9], 9'(i)}] = ERASED_BYTE;
    @(posedge clk);
    #1;
  endtask : core_wr

  task automatic core_rd(input logic [15:0] a, input logic u);
    logic b;
    wait_ready();
    b = blocked(a, u);
    c_rd = 1'b1;
    c_addr = a;
    unprot = u;
    @(posedge clk);
    #1;
    c_rd = 1'b0;
    chk({frd, rdy}, {!b, 1'b0}, "code read strobe");
    if (!b)
      chk(faddr, a, "code read address");
    @(posedge clk);
    #1;
    chk(rvalid, 1'b1, "code read valid");
    chk(rdata, b ? DENIED_BYTE : shadow[a], "code read data");
  endtask : core_rd

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {s_wr, x_wr, x_rd, c_rd, unprot} = 5'h00;
    {s_addr, s_wdata, c_wdata, c_addr} = 40'h0;
    ctrl_exp = CTRL_RESET;
    rng = 32'h0000aa7b;
    n_fail = 0;
    total_checks = 0;
    for (int i = 0; i < 65536; i++)
      shadow[i] = 8'(i ^ (i >> 8));
    // two low pages locked, which also locks the lock byte page
    shadow[LOCK_BYTE_64K] = 8'hfd;
    for (int i = 0; i < 65536; i++)
      flash.mem[i] = shadow[i];
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    wait_ready();
    sfr_rd(CTRL_SFR_ADDR, CTRL_RESET);
    sfr_rd(8'h8e, 8'h00);
    // a write to a neighbouring address must leave the enables alone
    s_addr = 8'h8e;
    s_wdata = 8'h03;
    s_wr = 1'b1;
    @(posedge clk);
    #1;
    s_wr = 1'b0;
    sfr_rd(CTRL_SFR_ADDR, CTRL_RESET);
    core_wr(16'h0410, 8'h5a, 1'b0);
    sfr_wr(8'hfe);
    sfr_rd(CTRL_SFR_ADDR, 8'h02);
    core_wr(16'h0420, 8'h00, 1'b0);
    sfr_wr(8'h03);
    ext_ram_rd(16'h0430);
    core_wr(16'h0434, 8'h00, 1'b0);
    core_rd(16'h05ff, 1'b0);
    sfr_wr(8'h01);
    core_wr(16'h0434, 8'ha7, 1'b0);
    core_rd(16'h0434, 1'b0);
    core_rd(16'h0000, 1'b1);
    core_rd(16'h03ff, 1'b1);
    core_rd(16'h0400, 1'b1);
    core_rd(16'hfa00, 1'b1);
    core_rd(16'h03ff, 1'b0);
    core_wr(16'h0200, 8'h00, 1'b1);
    core_rd(16'hfc00, 1'b0);
    core_wr(16'hfe00, 8'h00, 1'b0);
    for (int j = 0; j < 300; j++)
    begin
      rng = xorshift(rng);
      case (rng[1:0])
        2'd0: core_rd(rng[31:16], rng[2]);
        2'd1: ext_ram_rd(rng[31:16]);
        2'd2: core_wr(rng[31:16], rng[15:8], rng[2]);
        default:
        begin
          sfr_wr(rng[15:8]);
          core_rd(rng[31:16], rng[2]);
        end
      endcase
    end
    // a second reset clears the enables but keeps flash contents
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    ctrl_exp = CTRL_RESET;
    wait_ready();
    sfr_rd(CTRL_SFR_ADDR, CTRL_RESET);
    core_rd(16'h0000, 1'b1);
    end_sim();
  end
endmodule : flash_program_store_guard_tb
`default_nettype wire
